// ---- rtl/lane_signal_integrity_eq_control.sv ----
// The address map and the APB slave port were left to the implementer.
module lane_signal_integrity_eq_control
    import si_eq_pkg::*;
#(
    parameter int NLANES = 8,
    parameter int NBUF = 4,
    parameter int EQW = 8,
    parameter bit SINGLE_EMPH = 1'b0
)(
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Data path state per lane
    input wire logic [LANES-1:0] PATH_INITIALIZED,
    input wire logic [LANES-1:0] PATH_ACTIVE,
    // Adaptive equalizer
    input wire logic [LANES*EQW-1:0] EQ_LIVE,
    output logic [LANES-1:0] TX_ADAPT_RUN,
    output logic [LANES-1:0] EQ_LOAD,
    output logic [EQW-1:0] EQ_LOAD_VALUE,
    // Decoded settings to the analog side
    output lane_cfg_t [LANES-1:0] TX_EQ_CFG,
    output lane_cfg_t [LANES-1:0] RX_PRE_CFG,
    output lane_cfg_t [LANES-1:0] RX_POST_CFG,
    output lane_cfg_t [LANES-1:0] RX_SWING_CFG
);
    localparam int DEPTH = NBUF * LANES;
    localparam int AW = $clog2(DEPTH);
    localparam logic [LANES-1:0] LMASK = LANES'((1 << NLANES) - 1);

    // Refuse shapes that the nibble packing cannot hold
    // Checked while elaborating, so a bad build never gets to run
    if (NLANES < 1 || NLANES > LANES || NBUF < 1 || NBUF > 15 || EQW < 1) begin : bad_shape
        $error("lane_signal_integrity_eq_control: unsupported parameters");
    end

    // Tx host code to level
    function automatic lane_cfg_t dec_tx(input logic [3:0] c);
        lane_cfg_t d;
        d = '0;
        d.custom = (c > TX_MAX);
        d.level = d.custom ? 5'h00 : {1'b0, c};
        return d;
    endfunction

    // Emphasis code to half-dB units; post steps are twice pre steps
    function automatic lane_cfg_t dec_emph(input logic [3:0] c, input logic post);
        lane_cfg_t d;
        d = '0;
        d.custom = (c >= EMPH_CUSTOM_LO);
        d.reserved = (c >= EMPH_RSVD_LO) && !d.custom;
        if (c < EMPH_RSVD_LO) begin
            d.level = post ? {c, 1'b0} : {1'b0, c};
        end
        return d;
    endfunction

    // Swing code to range index
    function automatic lane_cfg_t dec_swing(input logic [3:0] c);
        lane_cfg_t d;
        d = '0;
        d.custom = (c == SWING_CUSTOM);
        d.reserved = (c > SWING_MAX) && !d.custom;
        d.level = (c <= SWING_MAX) ? {1'b0, c} : 5'h00;
        return d;
    endfunction

    // Lowest set bit index
    function automatic logic [2:0] first_lane(input logic [LANES-1:0] m);
        logic [2:0] k;
        k = '0;
        for (int i = LANES - 1; i >= 0; i--) begin
            if (m[i]) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction

    // Buffer number (1-based) and lane to memory address
    function automatic logic [AW-1:0] buf_addr(input logic [3:0] b, input logic [2:0] l);
        return AW'((32'(b) - 32'd1) * LANES + 32'(l));
    endfunction

    ctrl_set_t stg_r [NSETS];
    ctrl_set_t act_r;
    ctrl_set_t sel_set;
    logic [31:0] restored_r;
    logic [LANES-1:0] save_pend_r;
    logic [31:0] save_buf_r;
    logic [LANES-1:0] rcl_pend_r;
    seq_t st_r;
    logic [2:0] cur_r;
    logic [EQW-1:0] rd_data;
    logic wr_en;
    logic rd_en;
    logic save_wr;
    logic apply_wr;
    logic apply_ok;
    logic [LANES-1:0] path_up;
    logic [LANES-1:0] save_req;
    logic [LANES-1:0] apply_lanes;
    logic [31:0] rd_mux;
    logic mapped;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;
    assign save_wr = wr_en && (PADDR == SAVE_OFS);
    assign apply_wr = wr_en && (PADDR == APPLY_OFS);
    assign path_up = (PATH_INITIALIZED | PATH_ACTIVE) & LMASK;
    assign sel_set = stg_r[PWDATA[APPLY_SET_POS]];
    assign PREADY = 1'b1;

    // Reinit apply hits all lanes; hot apply only initialized or active paths
    always_comb begin
        apply_lanes = '0;
        if (apply_wr && PWDATA[APPLY_REINIT_POS]) begin
            apply_lanes = LMASK;
        end else if (apply_wr && PWDATA[APPLY_HOT_POS]) begin
            apply_lanes = path_up;
        end
    end
    assign apply_ok = |apply_lanes;

    // Per-lane save requests: nonzero buffer within range, adapting, path up
    always_comb begin
        save_req = '0;
        for (int i = 0; i < LANES; i++) begin
            if (save_wr && PWDATA[i*4 +: 4] != 4'h0 && 32'(PWDATA[i*4 +: 4]) <= NBUF
                    && act_r.adapt[i] && path_up[i]) begin
                save_req[i] = 1'b1;
            end
        end
    end

    // Staged sets are plain host storage
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int s = 0; s < NSETS; s++) begin
                stg_r[s] <= '0;
            end
        end else if (CE && wr_en) begin
            for (int s = 0; s < NSETS; s++) begin
                if (PADDR >= (s == 0 ? SET0_BASE : SET1_BASE)
                        && PADDR <= (s == 0 ? SET0_BASE : SET1_BASE) + 8'(RESTORE_W)) begin
                    unique case (5'(PADDR - (s == 0 ? SET0_BASE : SET1_BASE)))
                        CTRL_W: begin
                            stg_r[s].adapt <= PWDATA[ADAPT_POS +: 8];
                            stg_r[s].hold <= PWDATA[HOLD_POS +: 8];
                            stg_r[s].ovr <= PWDATA[OVR_POS +: 8];
                        end
                        TXEQ_W: stg_r[s].txeq <= PWDATA;
                        PRE_W: stg_r[s].pre <= PWDATA;
                        POST_W: stg_r[s].post <= PWDATA;
                        SWING_W: stg_r[s].swing <= PWDATA;
                        RESTORE_W: stg_r[s].restore <= PWDATA;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Apply copies host values or defaults per lane; restore always copied
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            act_r <= '0;
        end else if (CE && apply_ok) begin
            act_r.restore <= sel_set.restore;
            for (int i = 0; i < LANES; i++) begin
                if (apply_lanes[i]) begin
                    act_r.ovr[i] <= sel_set.ovr[i];
                    if (sel_set.ovr[i]) begin
                        act_r.adapt[i] <= sel_set.adapt[i];
                        act_r.hold[i] <= sel_set.hold[i];
                        act_r.txeq[i*4 +: 4] <= sel_set.txeq[i*4 +: 4];
                        act_r.pre[i*4 +: 4] <= sel_set.pre[i*4 +: 4];
                        act_r.post[i*4 +: 4] <= sel_set.post[i*4 +: 4];
                        act_r.swing[i*4 +: 4] <= sel_set.swing[i*4 +: 4];
                    end else begin
                        act_r.adapt[i] <= DEF_ADAPT;
                        act_r.hold[i] <= DEF_HOLD;
                        act_r.txeq[i*4 +: 4] <= DEF_TXEQ;
                        act_r.pre[i*4 +: 4] <= DEF_EMPH;
                        act_r.post[i*4 +: 4] <= DEF_EMPH;
                        act_r.swing[i*4 +: 4] <= DEF_SWING;
                    end
                end
            end
        end
    end

    // Pending saves; a new request wins over the service clear
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            save_pend_r <= '0;
            save_buf_r <= '0;
        end else if (CE) begin
            for (int i = 0; i < LANES; i++) begin
                if (save_req[i]) begin
                    save_pend_r[i] <= 1'b1;
                    save_buf_r[i*4 +: 4] <= PWDATA[i*4 +: 4];
                end else if (st_r == ST_SAVE && 3'(i) == cur_r) begin
                    save_pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Pending restores, armed only by an apply on lanes with a valid buffer
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rcl_pend_r <= '0;
        end else if (CE) begin
            for (int i = 0; i < LANES; i++) begin
                if (apply_lanes[i] && sel_set.restore[i*4 +: 4] != 4'h0
                        && 32'(sel_set.restore[i*4 +: 4]) <= NBUF) begin
                    rcl_pend_r[i] <= 1'b1;
                end else if (st_r == ST_LD && 3'(i) == cur_r) begin
                    rcl_pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Sequencer; saves first so a stored value is never stale
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= ST_IDLE;
            cur_r <= '0;
        end else if (CE) begin
            unique case (st_r)
                ST_IDLE: begin
                    if (|save_pend_r) begin
                        st_r <= ST_SAVE;
                        cur_r <= first_lane(save_pend_r);
                    end else if (|rcl_pend_r) begin
                        st_r <= ST_RD;
                        cur_r <= first_lane(rcl_pend_r);
                    end
                end
                ST_SAVE: st_r <= ST_IDLE;
                ST_RD: st_r <= ST_LD;
                ST_LD: st_r <= ST_IDLE;
            endcase
        end
    end

    // Buffers shared by all sets; one word per lane per buffer
    eq_save_mem #(.W(EQW), .DEPTH(DEPTH)) u_mem (
        .clk(MCLK),
        .ce(CE),
        .we(st_r == ST_SAVE),
        .waddr(buf_addr(save_buf_r[cur_r*4 +: 4], cur_r)),
        .wdata(EQ_LIVE[cur_r*EQW +: EQW]),
        .re(st_r == ST_RD),
        .raddr(buf_addr(act_r.restore[cur_r*4 +: 4], cur_r)),
        .rdata(rd_data)
    );

    // Load pulse and restored status
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            EQ_LOAD <= '0;
            EQ_LOAD_VALUE <= '0;
            restored_r <= '0;
        end else if (CE) begin
            EQ_LOAD <= '0;
            if (st_r == ST_LD) begin
                EQ_LOAD[cur_r] <= 1'b1;
                EQ_LOAD_VALUE <= rd_data;
                restored_r[cur_r*4 +: 4] <= act_r.restore[cur_r*4 +: 4];
            end
        end
    end

    // Adaptation runs unless held, disabled, or this lane is busy
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            TX_ADAPT_RUN <= '0;
        end else if (CE) begin
            for (int i = 0; i < LANES; i++) begin
                TX_ADAPT_RUN[i] <= LMASK[i] && act_r.adapt[i] && !act_r.hold[i]
                    && !save_pend_r[i] && !save_req[i] && !rcl_pend_r[i];
            end
        end
    end

    // Decoded settings; fields outside the lane's mode forced off
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            TX_EQ_CFG <= '0;
            RX_PRE_CFG <= '0;
            RX_POST_CFG <= '0;
            RX_SWING_CFG <= '0;
        end else if (CE) begin
            for (int i = 0; i < LANES; i++) begin
                TX_EQ_CFG[i] <= (act_r.adapt[i] || !LMASK[i]) ? '0
                    : dec_tx(act_r.txeq[i*4 +: 4]);
                RX_PRE_CFG[i] <= SINGLE_EMPH ? '0
                    : dec_emph(act_r.pre[i*4 +: 4], 1'b0);
                RX_POST_CFG[i] <= dec_emph(act_r.post[i*4 +: 4], 1'b1);
                RX_SWING_CFG[i] <= dec_swing(act_r.swing[i*4 +: 4]);
            end
        end
    end

    // Read mux and decode of mapped addresses
    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        unique case (PADDR)
            ADV_OFS: begin
                rd_mux[ADV_TX_SUP_POS] = 1'b1;
                rd_mux[ADV_EMPH_SUP_POS] = 1'b1;
                rd_mux[ADV_SWING_SUP_POS] = 1'b1;
                rd_mux[ADV_SINGLE_POS] = SINGLE_EMPH;
                rd_mux[ADV_TX_MAX_POS +: 4] = TX_MAX;
                rd_mux[ADV_EMPH_MAX_POS +: 4] = EMPH_MAX;
                rd_mux[ADV_SWING_MAX_POS +: 4] = SWING_MAX;
                rd_mux[ADV_NBUF_POS +: 4] = 4'(NBUF);
            end
            STATUS_OFS: rd_mux = {22'h0, st_r, save_pend_r};
            SAVE_OFS, APPLY_OFS: rd_mux = '0;
            SET0_BASE + 8'(CTRL_W): rd_mux = {8'h0, stg_r[0].ovr, stg_r[0].hold, stg_r[0].adapt};
            SET0_BASE + 8'(TXEQ_W): rd_mux = stg_r[0].txeq;
            SET0_BASE + 8'(PRE_W): rd_mux = stg_r[0].pre;
            SET0_BASE + 8'(POST_W): rd_mux = stg_r[0].post;
            SET0_BASE + 8'(SWING_W): rd_mux = stg_r[0].swing;
            SET0_BASE + 8'(RESTORE_W): rd_mux = stg_r[0].restore;
            SET1_BASE + 8'(CTRL_W): rd_mux = {8'h0, stg_r[1].ovr, stg_r[1].hold, stg_r[1].adapt};
            SET1_BASE + 8'(TXEQ_W): rd_mux = stg_r[1].txeq;
            SET1_BASE + 8'(PRE_W): rd_mux = stg_r[1].pre;
            SET1_BASE + 8'(POST_W): rd_mux = stg_r[1].post;
            SET1_BASE + 8'(SWING_W): rd_mux = stg_r[1].swing;
            SET1_BASE + 8'(RESTORE_W): rd_mux = stg_r[1].restore;
            ACT_BASE + 8'(CTRL_W): rd_mux = {8'h0, act_r.ovr, act_r.hold, act_r.adapt};
            ACT_BASE + 8'(TXEQ_W): rd_mux = act_r.txeq;
            ACT_BASE + 8'(PRE_W): rd_mux = act_r.pre;
            ACT_BASE + 8'(POST_W): rd_mux = act_r.post;
            ACT_BASE + 8'(SWING_W): rd_mux = act_r.swing;
            ACT_BASE + 8'(RESTORE_W): rd_mux = restored_r;
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in setup so it is stable through access
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= '0;
        end else if (CE && rd_en) begin
            PRDATA <= rd_mux;
        end
    end

    // Unmapped addresses fail in the access phase
    assign PSLVERR = PSEL && PENABLE && !mapped;

    AST_SAVE_PAUSE: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && st_r == ST_SAVE) |-> !TX_ADAPT_RUN[cur_r])
        else $error("adaptation ran during save");

    AST_SAVE_IGNORED: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && save_wr && !act_r.adapt[0] && !save_pend_r[0]) |=> !save_pend_r[0])
        else $error("save taken with adaptation off");

    AST_SAVE_DONE: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && |save_req && !(|{save_pend_r, rcl_pend_r})) |-> ##2 st_r == ST_SAVE)
        else $error("save not started at once");

    AST_RESTORE_COPY: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && apply_ok) |=> act_r.restore == $past(sel_set.restore))
        else $error("restore select not copied on apply");

    AST_DEFAULTS: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && apply_lanes[0] && !sel_set.ovr[0]) |=> act_r.swing[3:0] == DEF_SWING)
        else $error("default not loaded with override clear");

    AST_TX_IGNORED: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && act_r.adapt[0]) |=> TX_EQ_CFG[0] == '0)
        else $error("host target used while adapting");

    AST_TX_CUSTOM: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && !act_r.adapt[0] && act_r.txeq[3:0] == 4'hD) |=> TX_EQ_CFG[0].custom)
        else $error("tx code 13 not custom");

    AST_SWING_RSVD: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && act_r.swing[3:0] == 4'hE) |=> RX_SWING_CFG[0].reserved && !RX_SWING_CFG[0].custom)
        else $error("swing code 14 not reserved");

    AST_POST_STEP: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && act_r.post[3:0] == 4'h7) |=> RX_POST_CFG[0].level == 5'h0E)
        else $error("post code 7 not 14 half dB");

    AST_RECALL_LOAD: assert property (@(posedge MCLK) disable iff (!RESETN)
        (CE && st_r == ST_RD) |=> CE [*1] ##0 st_r == ST_LD ##1 EQ_LOAD != '0)
        else $error("restore load pulse missing");
endmodule

// ---- rtl/si_eq_pkg.sv ----
package si_eq_pkg;
    localparam int LANES = 8;
    localparam int NSETS = 2;
    // Byte offsets
    localparam logic [7:0] ADV_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SAVE_OFS = 8'h08;
    localparam logic [7:0] APPLY_OFS = 8'h0C;
    localparam logic [7:0] SET0_BASE = 8'h20;
    localparam logic [7:0] SET1_BASE = 8'h40;
    localparam logic [7:0] ACT_BASE = 8'h60;
    // Word offsets inside a control set
    localparam logic [4:0] CTRL_W = 5'h00;
    localparam logic [4:0] TXEQ_W = 5'h04;
    localparam logic [4:0] PRE_W = 5'h08;
    localparam logic [4:0] POST_W = 5'h0C;
    localparam logic [4:0] SWING_W = 5'h10;
    localparam logic [4:0] RESTORE_W = 5'h14;
    // CTRL word field positions
    localparam int ADAPT_POS = 0;
    localparam int HOLD_POS = 8;
    localparam int OVR_POS = 16;
    // APPLY word field positions
    localparam int APPLY_REINIT_POS = 0;
    localparam int APPLY_HOT_POS = 1;
    localparam int APPLY_SET_POS = 4;
    // Advertisement field positions and values
    localparam int ADV_TX_SUP_POS = 0;
    localparam int ADV_EMPH_SUP_POS = 1;
    localparam int ADV_SWING_SUP_POS = 2;
    localparam int ADV_SINGLE_POS = 3;
    localparam int ADV_TX_MAX_POS = 4;
    localparam int ADV_EMPH_MAX_POS = 8;
    localparam int ADV_SWING_MAX_POS = 12;
    localparam int ADV_NBUF_POS = 16;
    localparam logic [3:0] TX_MAX = 4'hC;
    localparam logic [3:0] EMPH_MAX = 4'h7;
    localparam logic [3:0] SWING_MAX = 4'h3;
    // Code boundaries
    localparam logic [3:0] EMPH_RSVD_LO = 4'h8;
    localparam logic [3:0] EMPH_CUSTOM_LO = 4'hB;
    localparam logic [3:0] SWING_CUSTOM = 4'hF;
    // Defaults loaded when the override bit is clear
    localparam logic [3:0] DEF_TXEQ = 4'h0;
    localparam logic [3:0] DEF_EMPH = 4'h0;
    localparam logic [3:0] DEF_SWING = 4'h1;
    localparam logic DEF_ADAPT = 1'b1;
    localparam logic DEF_HOLD = 1'b0;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] FIELD_RST = 32'h0000_0000;

    // One staged or active control set
    typedef struct packed {
        logic [7:0] ovr;
        logic [7:0] hold;
        logic [7:0] adapt;
        logic [31:0] txeq;
        logic [31:0] pre;
        logic [31:0] post;
        logic [31:0] swing;
        logic [31:0] restore;
    } ctrl_set_t;

    // Decoded per-lane setting: level in dB, half dB or range code
    typedef struct packed {
        logic custom;
        logic reserved;
        logic [4:0] level;
    } lane_cfg_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_RD, ST_LD} seq_t;
endpackage

// ---- rtl/eq_save_mem.sv ----
module eq_save_mem #(
    parameter int W = 8,
    parameter int DEPTH = 32
)(
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Write side
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read side
    input wire logic re,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    // Storage write; contents undefined until saved
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        if (ce && re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ---- bench/eq_model.sv ----
module eq_model
    import si_eq_pkg::*;
#(
    parameter int EQW = 8
)(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Equalizer control from the block
    input wire logic [LANES-1:0] TX_ADAPT_RUN,
    input wire logic [LANES-1:0] EQ_LOAD,
    input wire logic [EQW-1:0] EQ_LOAD_VALUE,
    // Live adapted value per lane
    output logic [LANES*EQW-1:0] EQ_LIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Loads win over adaptation, so a restored value becomes the new start point
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            EQ_LIVE <= '0;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                if (EQ_LOAD[i]) begin
                    EQ_LIVE[i*EQW +: EQW] <= EQ_LOAD_VALUE;
                end else if (TX_ADAPT_RUN[i]) begin
                    EQ_LIVE[i*EQW +: EQW] <= EQ_LIVE[i*EQW +: EQW] + EQW'(i + 3);
                end
            end
        end
    end
endmodule

// ---- bench/testbench.sv ----
module testbench
    import si_eq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus and observed signals
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, path_init = 8'h00, path_act = 8'h00, saved;
    logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h3D, wd;
    logic pready, pslverr, err;
    logic [LANES*8-1:0] eq_live;
    logic [LANES-1:0] run, load;
    logic [7:0] load_val;
    lane_cfg_t [LANES-1:0] txc, prc, poc, swc;
    int num_errors = 0, num_checks = 0;
    // Design and equalizer model
    lane_signal_integrity_eq_control uut (.MCLK(clk), .RESETN(rst_n), .CE(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PATH_INITIALIZED(path_init), .PATH_ACTIVE(path_act),
        .EQ_LIVE(eq_live), .TX_ADAPT_RUN(run), .EQ_LOAD(load), .EQ_LOAD_VALUE(load_val),
        .TX_EQ_CFG(txc), .RX_PRE_CFG(prc), .RX_POST_CFG(poc), .RX_SWING_CFG(swc));
    eq_model eqm (.MCLK(clk), .RESETN(rst_n), .TX_ADAPT_RUN(run), .EQ_LOAD(load),
        .EQ_LOAD_VALUE(load_val), .EQ_LIVE(eq_live));
    // Clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Watchdog, far beyond the couple of hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Level is only meaningful for normal codes
    function automatic logic [6:0] norm(input logic [6:0] s);
        return (s[6] | s[5]) ? {s[6:5], 5'h00} : s;
    endfunction
    // Kind 0 tx, 1 pre, 2 post, 3 swing
    function automatic logic [6:0] exp_cfg(input int k, input logic [3:0] c);
        if (k == 0) return (c > 4'hC) ? 7'h40 : {3'h0, c};
        if (k == 3) return (c == 4'hF) ? 7'h40 : (c > 4'h3) ? 7'h20 : {3'h0, c};
        if (c > 4'hA) return 7'h40;
        if (c > 4'h7) return 7'h20;
        return (k == 2) ? {2'h0, c, 1'b0} : {3'h0, c};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADV_OFS, 32'h0);
        chk("adv", rd, 32'h0004_37C7);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        chk("unmapped", rd, 32'h0);
        apb(1'b1, SET0_BASE + {3'h0, CTRL_W}, 32'h00FF_0000);
        // Two fixed rounds cover all sixteen codes and lane 0 corners, then random words
        for (int r = 0; r < 5; r++) begin
            lf = (r > 1) ? lfsr(lf) : lf;
            wd = (r == 0) ? 32'h6547_320D : (r == 1) ? 32'hFECB_A981 : lf;
            apb(1'b1, SET0_BASE + {3'h0, TXEQ_W}, wd);
            apb(1'b1, SET0_BASE + {3'h0, PRE_W}, wd);
            apb(1'b1, SET0_BASE + {3'h0, POST_W}, {wd[15:0], wd[31:16]});
            apb(1'b1, SET0_BASE + {3'h0, SWING_W}, ~wd);
            apb(1'b1, APPLY_OFS, 32'h1);
            repeat (3) @(posedge clk);
            #1;
            for (int l = 0; l < LANES; l++) begin
                chk("tx", norm(txc[l]), exp_cfg(0, wd[4*l +: 4]));
                chk("pre", norm(prc[l]), exp_cfg(1, wd[4*l +: 4]));
                chk("post", norm(poc[l]), exp_cfg(2, wd[(4*l + 16) % 32 +: 4]));
                chk("swing", norm(swc[l]), exp_cfg(3, ~wd[4*l +: 4]));
            end
        end
        // Save with adaptation off must leave nothing pending
        path_init <= 8'h01;
        apb(1'b1, SAVE_OFS, 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("save_off", rd, 32'h0);
        // Lane 0 now up through the active state instead
        path_init <= 8'h00;
        path_act <= 8'h01;
        apb(1'b1, SET0_BASE + {3'h0, CTRL_W}, 32'h00FF_00FF);
        apb(1'b1, APPLY_OFS, 32'h1);
        repeat (8) @(posedge clk);
        #1;
        chk("tx_adapting", txc[0], 32'h0);
        chk("run", run[0], 32'h1);
        apb(1'b1, SAVE_OFS, 32'h22);
        @(posedge clk);
        #1;
        chk("run_save", run[0], 32'h0);
        chk("run_down_lane", run[1], 32'h1);
        saved = eq_live[7:0];
        repeat (6) @(posedge clk);
        #1;
        chk("run_resume", run[0], 32'h1);
        apb(1'b1, SET0_BASE + {3'h0, RESTORE_W}, 32'h2);
        apb(1'b1, SET0_BASE + {3'h0, CTRL_W}, 32'h00FF_01FF);
        repeat (3) @(posedge clk);
        #1;
        chk("no_early_load", load, 32'h0);
        apb(1'b1, APPLY_OFS, 32'h2);
        for (int n = 0; n < 40 && load[0] !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("load_value", load_val, saved);
        repeat (3) @(posedge clk);
        #1;
        chk("frozen", run[0], 32'h0);
        chk("held_value", eq_live[7:0], saved);
        apb(1'b0, ACT_BASE + {3'h0, RESTORE_W}, 32'h0);
        chk("restored", rd[3:0], 32'h2);
        apb(1'b1, SET0_BASE + {3'h0, CTRL_W}, 32'h0);
        apb(1'b1, APPLY_OFS, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        chk("def_swing", swc[3], {28'h0, DEF_SWING});
        chk("def_tx", txc[3], 32'h0);
        end_of_test();
    end
endmodule
